// *** hdl/camc_map.svh ***
// constants and register map of the call answer mode controller
// Functional notes
// [RULE1] Manual mode: a lifted handset keeps the line on speech; start then moves it to the modem.
// [RULE2] Fax mode: a detected ring moves the line to the modem and starts the answer sequence.
// [RULE3] Auto mode: a detected ring moves the line to the modem with the ringer kept off.
// [RULE4] Auto mode: calling-tone watch starts at the ring; the voice message starts 3.5 s later.
// [RULE5] Auto mode: summoning of the local user starts 7 s after the ring.
// [RULE6] Auto mode: calling tone during message or summons leads to fax answer.
// [RULE7] Auto mode: a lifted handset returns the line to the speech circuit.
// [RULE8] Auto mode: with no tone and no pickup in 30 s, answer as fax and then release the line.
// [RULE9] Machine mode: ring count N is programmable and the line is seized on ring N+1.
// [RULE10] Machine mode: pickup by the external machine is seen on the line-current sense.
// [RULE11] Machine mode: after pickup, calling tone or a settable silence (5 s) leads to fax answer.
// [RULE12] The line-current sense is active low: low means loop current flows.
// [RULE13] Timers run from the first ring on the system clock; a sync reset returns to idle.
`ifndef CAMC_MAP_SVH
`define CAMC_MAP_SVH
// register byte offsets
`define CAMC_CTRL_OFS 8'h00
`define CAMC_SIL_OFS 8'h04
`define CAMC_CMD_OFS 8'h08
`define CAMC_STAT_OFS 8'h0c
// field positions
`define CAMC_CTRL_MODE_LSB 0
`define CAMC_CTRL_RINGN_LSB 4
`define CAMC_CMD_START_BIT 0
`define CAMC_CMD_SRST_BIT 1
`define CAMC_STAT_RELAY_BIT 4
`define CAMC_STAT_RINGC_LSB 8
// reset values
`define CAMC_RINGN_RST 4'h2
// timing in ms and the clock rate
`define CAMC_CLK_MHZ 250
`define CAMC_MS_CYC (`CAMC_CLK_MHZ * 1000)
`define CAMC_VOICE_MS 16'd3500
`define CAMC_USER_MS 16'd7000
`define CAMC_GIVEUP_MS 16'd30000
`define CAMC_SIL_MS_RST 16'd5000
`define CAMC_ANS_MS 16'd3000
`define CAMC_RING_GAP_MS 16'd8000
`endif

// *** hdl/camc_pkg.sv ***
// types of the call answer mode controller
package camc_pkg;
  // answer modes
  typedef enum logic [1:0] {
    MODE_MAN = 2'b00,
    MODE_FAX = 2'b01,
    MODE_AUTO = 2'b10,
    MODE_TAM = 2'b11
  } camc_mode_t;
  // controller states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TALK = 3'b001,
    ST_FAX = 3'b010,
    ST_RX = 3'b011,
    ST_AUTO = 3'b100,
    ST_REL = 3'b101,
    ST_TAM_WAIT = 3'b110,
    ST_TAM_MON = 3'b111
  } camc_st_t;
  // all state of the controller
  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic ring_q;
    camc_st_t st;
    logic [17:0] tick;
    logic [15:0] ms;
    logic [3:0] ring_cnt;
    camc_mode_t mode;
    logic [3:0] ring_n;
    logic [15:0] sil_ms;
    logic start_ff;
    logic srst_ff;
    logic wr_ph;
    logic [7:0] ad_ph;
    logic [31:0] hrdata;
    logic hready;
    logic relay;
    logic ringer;
    logic ans;
    logic voice;
    logic user_call;
  } camc_state_t;
endpackage : camc_pkg

// *** hdl/camc_top.sv ***
// call answer mode controller with ahb-lite register slave
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`include "camc_map.svh"
module camc_top #(
  parameter int unsigned MS_CYCLES = `CAMC_MS_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // line detectors, asynchronous
  input wire logic ring_det_i,
  input wire logic hook_off_i,
  input wire logic line_cur_n_i,
  input wire logic cng_det_i,
  input wire logic silence_i,
  // line control
  output logic line_select_relay_o,
  output logic ringer_en_o,
  output logic ans_seq_o,
  output logic voice_msg_o,
  output logic user_call_o
);
  localparam logic [17:0] TICK_LAST = 18'(MS_CYCLES - 1);

  camc_pkg::camc_state_t s_ff;
  camc_pkg::camc_state_t nxt_s;
  logic ring_s;
  logic hook_s;
  logic cur_n_s;
  logic cng_s;
  logic sil_s;
  logic ring_edge;

  // synchronised detector levels
  assign ring_s = s_ff.sy2[0];
  assign hook_s = s_ff.sy2[1];
  assign cur_n_s = s_ff.sy2[2];
  assign cng_s = s_ff.sy2[3];
  assign sil_s = s_ff.sy2[4];
  assign ring_edge = ring_s & ~s_ff.ring_q;

  // next state of everything
  always_comb begin
    logic restart;
    restart = 1'b0;
    nxt_s = s_ff;
    // two-stage synchronisers for pins
    nxt_s.sy1 = {silence_i, cng_det_i, line_cur_n_i, hook_off_i, ring_det_i};
    nxt_s.sy2 = s_ff.sy1;
    nxt_s.ring_q = ring_s;
    nxt_s.start_ff = 1'b0;
    nxt_s.srst_ff = 1'b0;
    nxt_s.hready = 1'b1;
    // data phase: register writes, ahead of the read mux
    if (s_ff.wr_ph) begin
      case (s_ff.ad_ph)
        `CAMC_CTRL_OFS: begin
          nxt_s.mode = camc_pkg::camc_mode_t'(hwdata_i[`CAMC_CTRL_MODE_LSB +: 2]);
          nxt_s.ring_n = hwdata_i[`CAMC_CTRL_RINGN_LSB +: 4];
        end
        `CAMC_SIL_OFS: nxt_s.sil_ms = hwdata_i[15:0];
        `CAMC_CMD_OFS: begin
          nxt_s.start_ff = hwdata_i[`CAMC_CMD_START_BIT];
          nxt_s.srst_ff = hwdata_i[`CAMC_CMD_SRST_BIT];
        end
        default: ;
      endcase
    end
    // address phase: latch write, prepare read data
    // a read pipelined right behind a write sees the written value
    nxt_s.wr_ph = hsel_i & htrans_i[1] & hready_i & hwrite_i;
    if (hsel_i && htrans_i[1] && hready_i) begin
      nxt_s.ad_ph = haddr_i[7:0];
      case (haddr_i[7:0])
        `CAMC_CTRL_OFS: nxt_s.hrdata = {24'h000000, nxt_s.ring_n, 2'b00, nxt_s.mode};
        `CAMC_SIL_OFS: nxt_s.hrdata = {16'h0000, nxt_s.sil_ms};
        `CAMC_STAT_OFS: nxt_s.hrdata = {20'h00000, s_ff.ring_cnt, s_ff.user_call,
                                        s_ff.voice, s_ff.ans, s_ff.relay, s_ff.ringer,
                                        s_ff.st};
        default: nxt_s.hrdata = 32'h00000000;
      endcase
    end
    // [RULE13] system clock ms base
    if (s_ff.tick == TICK_LAST) begin
      nxt_s.tick = 18'h00000;
      if (s_ff.ms != 16'hffff) begin
        nxt_s.ms = s_ff.ms + 16'h0001;
      end
    end else begin
      nxt_s.tick = s_ff.tick + 18'h00001;
    end
    // call handling
    case (s_ff.st)
      camc_pkg::ST_IDLE: begin
        nxt_s.ring_cnt = 4'h0;
        if (s_ff.start_ff) begin
          nxt_s.st = camc_pkg::ST_RX;
        // [RULE1] handset keeps speech path
        end else if (hook_s) begin
          nxt_s.st = camc_pkg::ST_TALK;
        end else if (ring_edge) begin
          case (s_ff.mode)
            // [RULE2] ring answers as fax
            camc_pkg::MODE_FAX: nxt_s.st = camc_pkg::ST_FAX;
            // [RULE3] ring switches to modem
            camc_pkg::MODE_AUTO: nxt_s.st = camc_pkg::ST_AUTO;
            // [RULE9] count first ring
            camc_pkg::MODE_TAM: begin
              nxt_s.ring_cnt = 4'h1;
              nxt_s.st = (s_ff.ring_n == 4'h0) ? camc_pkg::ST_FAX : camc_pkg::ST_TAM_WAIT;
            end
            default: ;
          endcase
        end
      end
      camc_pkg::ST_TALK: begin
        // [RULE1] start moves line to modem
        if (s_ff.start_ff) begin
          nxt_s.st = camc_pkg::ST_RX;
        end else if (!hook_s) begin
          nxt_s.st = camc_pkg::ST_IDLE;
        end
      end
      camc_pkg::ST_FAX: begin
        if (s_ff.ms >= `CAMC_ANS_MS) begin
          nxt_s.st = camc_pkg::ST_RX;
        end
      end
      camc_pkg::ST_RX: begin
        // [RULE12] high sense means loop dropped
        if (cur_n_s && s_ff.ms >= `CAMC_ANS_MS) begin
          nxt_s.st = camc_pkg::ST_IDLE;
        end
      end
      camc_pkg::ST_AUTO: begin
        // [RULE6] calling tone wins
        if (cng_s) begin
          nxt_s.st = camc_pkg::ST_FAX;
        // [RULE7] pickup returns to speech
        end else if (hook_s) begin
          nxt_s.st = camc_pkg::ST_TALK;
        // [RULE8] give up after 30 s
        end else if (s_ff.ms >= `CAMC_GIVEUP_MS) begin
          nxt_s.st = camc_pkg::ST_REL;
        end
      end
      camc_pkg::ST_REL: begin
        if (s_ff.ms >= `CAMC_ANS_MS) begin
          nxt_s.st = camc_pkg::ST_IDLE;
        end
      end
      camc_pkg::ST_TAM_WAIT: begin
        // [RULE10] loop current shows machine pickup
        if (!cur_n_s) begin
          nxt_s.st = camc_pkg::ST_TAM_MON;
        // [RULE9] seize on ring n+1
        end else if (ring_edge) begin
          restart = 1'b1;
          if (s_ff.ring_cnt == s_ff.ring_n) begin
            nxt_s.st = camc_pkg::ST_FAX;
          end else begin
            nxt_s.ring_cnt = s_ff.ring_cnt + 4'h1;
          end
        end else if (s_ff.ms >= `CAMC_RING_GAP_MS) begin
          nxt_s.st = camc_pkg::ST_IDLE;
        end
      end
      camc_pkg::ST_TAM_MON: begin
        // [RULE11] tone or silence means fax
        if (cng_s) begin
          nxt_s.st = camc_pkg::ST_FAX;
        end else if (cur_n_s) begin
          nxt_s.st = camc_pkg::ST_IDLE;
        end else if (!sil_s) begin
          restart = 1'b1;
        end else if (s_ff.ms >= s_ff.sil_ms) begin
          nxt_s.st = camc_pkg::ST_FAX;
        end
      end
      default: nxt_s.st = camc_pkg::ST_IDLE;
    endcase
    // [RULE13] command reset to idle
    if (s_ff.srst_ff) begin
      nxt_s.st = camc_pkg::ST_IDLE;
      nxt_s.ring_cnt = 4'h0;
    end
    // timers restart on every state entry
    if (restart || nxt_s.st != s_ff.st) begin
      nxt_s.tick = 18'h00000;
      nxt_s.ms = 16'h0000;
    end
    // registered line controls
    nxt_s.relay = nxt_s.st inside {camc_pkg::ST_FAX, camc_pkg::ST_RX,
                                   camc_pkg::ST_AUTO, camc_pkg::ST_REL};
    // [RULE3] ringer silent in auto mode
    nxt_s.ringer = (nxt_s.st == camc_pkg::ST_IDLE) && (s_ff.mode != camc_pkg::MODE_AUTO);
    nxt_s.ans = nxt_s.st inside {camc_pkg::ST_FAX, camc_pkg::ST_REL};
    // [RULE4] voice message stage
    nxt_s.voice = (nxt_s.st == camc_pkg::ST_AUTO) && (nxt_s.ms >= `CAMC_VOICE_MS);
    // [RULE5] user summons stage
    nxt_s.user_call = (nxt_s.st == camc_pkg::ST_AUTO) && (nxt_s.ms >= `CAMC_USER_MS);
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_ff <= '{sy1: 5'h04, sy2: 5'h04, ring_q: 1'b0, st: camc_pkg::ST_IDLE,
                tick: 18'h00000, ms: 16'h0000, ring_cnt: 4'h0,
                mode: camc_pkg::MODE_MAN, ring_n: `CAMC_RINGN_RST,
                sil_ms: `CAMC_SIL_MS_RST, start_ff: 1'b0, srst_ff: 1'b0,
                wr_ph: 1'b0, ad_ph: 8'h00, hrdata: 32'h00000000, hready: 1'b1,
                relay: 1'b0, ringer: 1'b1, ans: 1'b0, voice: 1'b0, user_call: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state register, except hresp_o which is tied low
  assign hrdata_o = s_ff.hrdata;
  assign hreadyout_o = s_ff.hready;
  assign hresp_o = 1'b0;
  assign line_select_relay_o = s_ff.relay;
  assign ringer_en_o = s_ff.ringer;
  assign ans_seq_o = s_ff.ans;
  assign voice_msg_o = s_ff.voice;
  assign user_call_o = s_ff.user_call;

  // checks of the call handling
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_man_start;
    (s_ff.st == camc_pkg::ST_TALK) && s_ff.start_ff && !s_ff.srst_ff
      |=> line_select_relay_o && (s_ff.st == camc_pkg::ST_RX);
  endproperty
  a_man_start: assert property (p_man_start) // [RULE1]
    else $error("start key did not move line to modem");

  property p_fax_ring;
    (s_ff.st == camc_pkg::ST_IDLE) && (s_ff.mode == camc_pkg::MODE_FAX) && ring_edge
      && !hook_s && !s_ff.start_ff && !s_ff.srst_ff |=> line_select_relay_o && ans_seq_o;
  endproperty
  a_fax_ring: assert property (p_fax_ring) // [RULE2]
    else $error("fax mode ring not answered");

  property p_auto_ringer;
    (s_ff.st == camc_pkg::ST_AUTO) |-> line_select_relay_o && !ringer_en_o;
  endproperty
  a_auto_ringer: assert property (p_auto_ringer) // [RULE3]
    else $error("auto mode relay or ringer wrong");

  property p_voice_time;
    $rose(voice_msg_o) |-> (s_ff.ms == `CAMC_VOICE_MS) && (s_ff.st == camc_pkg::ST_AUTO);
  endproperty
  a_voice_time: assert property (p_voice_time) // [RULE4]
    else $error("voice message started at wrong time");

  property p_user_time;
    $rose(user_call_o) |-> (s_ff.ms == `CAMC_USER_MS) && voice_msg_o;
  endproperty
  a_user_time: assert property (p_user_time) // [RULE5]
    else $error("user summons started at wrong time");

  property p_auto_cng;
    (s_ff.st == camc_pkg::ST_AUTO) && cng_s && !s_ff.srst_ff
      |=> (s_ff.st == camc_pkg::ST_FAX) ##1 ans_seq_o;
  endproperty
  a_auto_cng: assert property (p_auto_cng) // [RULE6]
    else $error("calling tone in auto mode not answered");

  property p_auto_hook;
    (s_ff.st == camc_pkg::ST_AUTO) && hook_s && !cng_s && !s_ff.srst_ff
      |=> !line_select_relay_o;
  endproperty
  a_auto_hook: assert property (p_auto_hook) // [RULE7]
    else $error("pickup did not return line to speech");

  property p_auto_giveup;
    (s_ff.st == camc_pkg::ST_AUTO) |-> (s_ff.ms <= `CAMC_GIVEUP_MS);
  endproperty
  a_auto_giveup: assert property (p_auto_giveup) // [RULE8]
    else $error("auto stage ran past 30 s");

  property p_tam_seize;
    (s_ff.st == camc_pkg::ST_TAM_WAIT) && cur_n_s && ring_edge
      && (s_ff.ring_cnt == s_ff.ring_n) && !s_ff.srst_ff |=> (s_ff.st == camc_pkg::ST_FAX);
  endproperty
  a_tam_seize: assert property (p_tam_seize) // [RULE9]
    else $error("line not seized on ring n+1");

  property p_tam_pickup;
    (s_ff.st == camc_pkg::ST_TAM_WAIT) && !cur_n_s && !s_ff.srst_ff
      |=> (s_ff.st == camc_pkg::ST_TAM_MON) && !line_select_relay_o;
  endproperty
  a_tam_pickup: assert property (p_tam_pickup) // [RULE10] [RULE12]
    else $error("machine pickup not seen");

  property p_tam_silence;
    (s_ff.st == camc_pkg::ST_TAM_MON) && !cng_s && !cur_n_s && sil_s
      && (s_ff.ms >= s_ff.sil_ms) && !s_ff.srst_ff
      |=> (s_ff.st == camc_pkg::ST_FAX) && ans_seq_o;
  endproperty
  a_tam_silence: assert property (p_tam_silence) // [RULE11]
    else $error("silence period overrun");

  property p_srst;
    s_ff.srst_ff |=> (s_ff.st == camc_pkg::ST_IDLE) && !line_select_relay_o;
  endproperty
  a_srst: assert property (p_srst) // [RULE13]
    else $error("command reset did not idle");

  property p_auto_giveup_rel;
    (s_ff.st == camc_pkg::ST_AUTO) && (s_ff.ms >= `CAMC_GIVEUP_MS) && !cng_s && !hook_s
      && !s_ff.srst_ff |=> (s_ff.st == camc_pkg::ST_REL) && ans_seq_o && line_select_relay_o;
  endproperty
  a_auto_giveup_rel: assert property (p_auto_giveup_rel) // [RULE8]
    else $error("no answer sequence after 30 s");

  property p_rel_drop;
    (s_ff.st == camc_pkg::ST_REL) && (s_ff.ms >= `CAMC_ANS_MS) && !s_ff.srst_ff
      |=> (s_ff.st == camc_pkg::ST_IDLE) && !line_select_relay_o && !ans_seq_o;
  endproperty
  a_rel_drop: assert property (p_rel_drop) // [RULE8]
    else $error("line not released after answer");

  property p_ring_cnt;
    (s_ff.st == camc_pkg::ST_TAM_WAIT) && cur_n_s && ring_edge
      && (s_ff.ring_cnt != s_ff.ring_n) && !s_ff.srst_ff
      |=> (s_ff.st == camc_pkg::ST_TAM_WAIT) && !line_select_relay_o;
  endproperty
  a_ring_cnt: assert property (p_ring_cnt) // [RULE9]
    else $error("line seized before ring n+1");

  // main scenarios
  c_auto_fax: cover property ((s_ff.st == camc_pkg::ST_AUTO) ##1 (s_ff.st == camc_pkg::ST_FAX));
  c_auto_talk: cover property ((s_ff.st == camc_pkg::ST_AUTO) ##1 (s_ff.st == camc_pkg::ST_TALK));
  c_tam_fax: cover property ((s_ff.st == camc_pkg::ST_TAM_MON) ##1 (s_ff.st == camc_pkg::ST_FAX));
  c_man_rx: cover property ((s_ff.st == camc_pkg::ST_TALK) ##1 (s_ff.st == camc_pkg::ST_RX));
  c_auto_rel: cover property ((s_ff.st == camc_pkg::ST_AUTO) ##1 (s_ff.st == camc_pkg::ST_REL));

endmodule // camc_top

// *** bench/camc_line_model.sv ***
// line and remote terminal model facing the controller
module camc_line_model (
  // bench commands
  input wire logic ring_cmd_i,
  input wire logic hook_cmd_i,
  input wire logic tam_cmd_i,
  input wire logic cng_cmd_i,
  input wire logic quiet_cmd_i,
  // device side
  input wire logic line_select_relay_i,
  // detector pins
  output logic ring_det_o,
  output logic hook_off_o,
  output logic line_cur_n_o,
  output logic cng_det_o,
  output logic silence_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic loop;
  // loop closed by modem, handset or external machine
  assign loop = line_select_relay_i | hook_cmd_i | tam_cmd_i;
  // ringing stops once anyone seizes the line
  assign ring_det_o = ring_cmd_i & ~loop;
  assign hook_off_o = hook_cmd_i;
  assign line_cur_n_o = ~loop;
  // tones and quiet only reach a seized line
  assign cng_det_o = cng_cmd_i & loop;
  assign silence_o = quiet_cmd_i & loop;
endmodule // camc_line_model

// *** bench/camc_tb.sv ***
// bench of the call answer mode controller
module camc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready;
  logic hresp;
  logic ring_cmd = 1'b0, hook_cmd = 1'b0, tam_cmd = 1'b0, cng_cmd = 1'b0, quiet_cmd = 1'b0;
  logic ring_det, hook_off, line_cur_n, cng_det, silence;
  logic relay, ringer, ans, voice, user;
  int num_errors = 0;
  int checks = 0;
  // 250 mhz clock
  always #2 sys_clk_i = ~sys_clk_i;
  // controller, two clocks per ms to keep the run short
  camc_top #(.MS_CYCLES(2)) camc_top_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .ring_det_i(ring_det), .hook_off_i(hook_off), .line_cur_n_i(line_cur_n),
    .cng_det_i(cng_det), .silence_i(silence), .line_select_relay_o(relay),
    .ringer_en_o(ringer), .ans_seq_o(ans), .voice_msg_o(voice), .user_call_o(user));
  // far side of the line
  camc_line_model camc_line_model_inst (
    .ring_cmd_i(ring_cmd), .hook_cmd_i(hook_cmd), .tam_cmd_i(tam_cmd),
    .cng_cmd_i(cng_cmd), .quiet_cmd_i(quiet_cmd), .line_select_relay_i(relay),
    .ring_det_o(ring_det), .hook_off_o(hook_off), .line_cur_n_o(line_cur_n),
    .cng_det_o(cng_det), .silence_o(silence));
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // one single ahb transfer, address phase then data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // soft reset through the command word
  task automatic srst();
    xfer(1'b1, 8'h08, 32'h2);
    wt(3);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // single-bit compare
  task automatic chkb(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask
  // one ring burst, cut short when the line is seized
  task automatic ring();
    ring_cmd <= 1'b1;
    for (int i = 0; i < 20 && relay !== 1'b1; i++) @(posedge sys_clk_i);
    ring_cmd <= 1'b0;
    wt(20);
  endtask
  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    wt(8);
    nrst_i <= 1'b1;
    wt(2);
    chkb("relay", 1'b0, relay);
    chkb("ringer", 1'b1, ringer);
    xfer(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h20, rd);
    xfer(1'b0, 8'h04, 32'h0);
    chk("sil", 32'h1388, rd);
    xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    // manual mode
    hook_cmd <= 1'b1;
    wt(6);
    chkb("relay", 1'b0, relay);
    xfer(1'b0, 8'h0c, 32'h0);
    chk("state", 32'h1, {29'h0, rd[2:0]});
    xfer(1'b1, 8'h08, 32'h1);
    wt(3);
    chkb("relay", 1'b1, relay);
    hook_cmd <= 1'b0;
    srst();
    chkb("relay", 1'b0, relay);
    // fax mode
    xfer(1'b1, 8'h00, 32'h21);
    ring();
    chkb("relay", 1'b1, relay);
    chkb("ans", 1'b1, ans);
    srst();
    // auto mode stages
    xfer(1'b1, 8'h00, 32'h22);
    ring();
    chkb("relay", 1'b1, relay);
    chkb("ringer", 1'b0, ringer);
    wt(6780);
    chkb("voice", 1'b0, voice);
    wt(400);
    chkb("voice", 1'b1, voice);
    wt(6600);
    chkb("user", 1'b0, user);
    wt(400);
    chkb("user", 1'b1, user);
    cng_cmd <= 1'b1;
    wt(5);
    chkb("ans", 1'b1, ans);
    cng_cmd <= 1'b0;
    srst();
    // auto mode, handset pickup
    ring();
    hook_cmd <= 1'b1;
    wt(6);
    chkb("relay", 1'b0, relay);
    hook_cmd <= 1'b0;
    wt(6);
    // auto mode, nobody answers
    ring();
    wt(59780);
    chkb("ans", 1'b0, ans);
    wt(400);
    chkb("ans", 1'b1, ans);
    wt(6000);
    chkb("relay", 1'b0, relay);
    // answering machine mode, seize on ring three
    xfer(1'b1, 8'h00, 32'h23);
    ring();
    ring();
    chkb("relay", 1'b0, relay);
    xfer(1'b0, 8'h0c, 32'h0);
    chk("ring count", 32'h2, {28'h0, rd[11:8]});
    ring();
    chkb("relay", 1'b1, relay);
    srst();
    // external machine answers, then quiet line
    xfer(1'b1, 8'h04, 32'h64);
    ring();
    tam_cmd <= 1'b1;
    wt(6);
    xfer(1'b0, 8'h0c, 32'h0);
    chk("state", 32'h7, {29'h0, rd[2:0]});
    chkb("relay", 1'b0, relay);
    quiet_cmd <= 1'b1;
    wt(150);
    chkb("ans", 1'b0, ans);
    wt(100);
    chkb("ans", 1'b1, ans);
    quiet_cmd <= 1'b0;
    tam_cmd <= 1'b0;
    srst();
    // external machine answers, then calling tone
    ring();
    tam_cmd <= 1'b1;
    wt(6);
    cng_cmd <= 1'b1;
    wt(6);
    chkb("ans", 1'b1, ans);
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    wt(100000);
    num_errors++;
    print_verdict();
  end
endmodule // camc_tb
